/* File: hw/ncoacc_phase_core.sv */
// Purpose: 20-bit phase accumulator with byte writes and overflow pulse
// Assumes: advance is a one-cycle pulse per source clock period
// Notes:   a byte write in the same cycle as an advance wins
`timescale 1ns/10ps
module ncoacc_phase_core
	import ncoacc_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 reset,
	input  wire logic                 advance,
	input  wire logic [19:0]          step_in,
	input  wire ncoacc_acc_write_type acc_wr,
	output logic      [19:0]          phase_accum,
	output logic                      overflow_pulse
);

	logic [20:0] sum;

	assign sum = {1'b0, phase_accum} + {1'b0, step_in};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			phase_accum <= {UPPER_PAD, RST_ACC_BYTE, RST_ACC_BYTE};
		end else if (acc_wr.wr_acc != 3'h0) begin
			if (acc_wr.wr_acc[0]) begin
				phase_accum[7:0] <= acc_wr.wdata;
			end
			if (acc_wr.wr_acc[1]) begin
				phase_accum[15:8] <= acc_wr.wdata;
			end
			if (acc_wr.wr_acc[2]) begin
				phase_accum[19:16] <= acc_wr.wdata[3:0];
			end
		end else if (advance) begin
			phase_accum <= sum[19:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			overflow_pulse <= 1'b0;
		end else begin
			overflow_pulse <= advance && (acc_wr.wr_acc == 3'h0) && sum[20];
		end
	end

endmodule : ncoacc_phase_core

/* File: hw/ncoacc_pkg.sv */
// Purpose: shared constants and types for the oscillator accumulator and step registers
// Assumes: byte-wide register port, one core clock
// Notes:   register offsets are word indices on the plain register port
package ncoacc_pkg;

	localparam int ACC_WIDTH  = 20;
	localparam int BYTE_WIDTH = 8;
	localparam int ADDR_WIDTH = 4;
	localparam int UPPER_BITS = 4;
	localparam int STEP_BYTES = 3;

	// register offsets
	localparam logic [3:0] OFS_ACC_LOW   = 4'h0;
	localparam logic [3:0] OFS_ACC_HIGH  = 4'h1;
	localparam logic [3:0] OFS_ACC_UPPER = 4'h2;
	localparam logic [3:0] OFS_STEP_LOW  = 4'h3;
	localparam logic [3:0] OFS_STEP_HIGH = 4'h4;
	localparam logic [3:0] OFS_STEP_UPPER= 4'h5;
	localparam logic [3:0] OFS_CONTROL   = 4'h6;
	localparam logic [3:0] OFS_STATUS    = 4'h7;

	// byte index of each step register inside the step array
	localparam logic [1:0] STEP_IDX_LOW   = 2'h0;
	localparam logic [1:0] STEP_IDX_HIGH  = 2'h1;
	localparam logic [1:0] STEP_IDX_UPPER = 2'h2;

	// field positions
	localparam int CTRL_ENABLE_BIT    = 0;
	localparam int STAT_PENDING_BIT   = 0;
	localparam int STAT_RUNNING_BIT   = 1;
	localparam int ACC_HIGH_LSB       = 8;
	localparam int ACC_UPPER_LSB      = 16;

	// reset values
	localparam logic [7:0]  RST_ACC_BYTE   = 8'h00;
	localparam logic [7:0]  RST_STEP_LOW   = 8'h01;
	localparam logic [7:0]  RST_STEP_HIGH  = 8'h00;
	localparam logic [7:0]  RST_STEP_UPPER = 8'h00;
	localparam logic [19:0] RST_SHADOW     = 20'h00001;
	localparam logic [7:0]  RST_CONTROL    = 8'h00;
	localparam logic [7:0]  READ_UNMAPPED  = 8'h00;
	localparam logic [3:0]  UPPER_PAD      = 4'h0;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} ncoacc_bus_req_type;

	typedef struct packed {
		logic [2:0] wr_acc;
		logic [7:0] wdata;
	} ncoacc_acc_write_type;

endpackage : ncoacc_pkg

/* File: hw/ncoacc_top.sv */
// Summary of operation
// - phase accumulator is 20 bits in low, high and upper byte registers
// - upper accumulator bits 7 to 4 read zero and ignore writes
// - accumulator runs on source clock, no atomic multi-byte access
// - step value is upper 19:16, high 15:8, low 7:0 concatenated
// - low step write loads shadow on next source clock falling edge
//
// Purpose: register front end and shadow step for the oscillator accumulator
// Assumes: osc_source_clock is sampled as a level synchronous to core_clk
// Notes:   the source clock must be slower than half of core_clk
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
module ncoacc_top
	import ncoacc_pkg::*;
(
	core_clk,
	reset,
	bus_req,
	bus_rdata,
	osc_source_clock,
	phase_accum,
	step_shadow,
	osc_overflow
);
	input  wire logic               core_clk;
	input  wire logic               reset;
	input  wire ncoacc_bus_req_type bus_req;
	output logic      [7:0]         bus_rdata;
	input  wire logic               osc_source_clock;
	output logic      [19:0]        phase_accum;
	output logic      [19:0]        step_shadow;
	output logic                    osc_overflow;

	// decoding shared by write and read paths
	function automatic logic addr_hit(
		input logic [3:0] addr,
		input logic [3:0] offset
	);
		addr_hit = (addr == offset);
	endfunction : addr_hit

	function automatic logic [1:0] step_index(
		input logic [3:0] addr
	);
		logic [1:0] idx;
		idx = STEP_IDX_LOW;
		if (addr_hit(addr, OFS_STEP_HIGH)) begin
			idx = STEP_IDX_HIGH;
		end else if (addr_hit(addr, OFS_STEP_UPPER)) begin
			idx = STEP_IDX_UPPER;
		end
		step_index = idx;
	endfunction : step_index

	logic [7:0]           step_value_reg [STEP_BYTES];
	logic [7:0]           step_reset     [STEP_BYTES];
	logic [19:0]          step_value;
	logic [19:0]          step_shadow_reg;
	logic                 shadow_pending_reg;
	logic                 enable_reg;
	logic                 src_prev_reg;
	logic                 src_rise;
	logic                 src_fall;
	logic                 step_write;
	logic                 step_low_write;
	logic [1:0]           step_widx;
	logic [7:0]           rdata_next;
	logic [7:0]           bus_rdata_reg;
	logic                 overflow_raw;
	ncoacc_acc_write_type acc_wr;

	assign step_reset[STEP_IDX_LOW]   = RST_STEP_LOW;
	assign step_reset[STEP_IDX_HIGH]  = RST_STEP_HIGH;
	assign step_reset[STEP_IDX_UPPER] = RST_STEP_UPPER;

	// write decode
	always_comb begin
		step_write     = 1'b0;
		step_low_write = 1'b0;
		step_widx      = step_index(bus_req.addr);
		acc_wr.wdata   = bus_req.wdata;
		acc_wr.wr_acc  = 3'h0;
		if (bus_req.wr) begin
			if (addr_hit(bus_req.addr, OFS_ACC_LOW)) begin
				acc_wr.wr_acc = 3'h1;
			end else if (addr_hit(bus_req.addr, OFS_ACC_HIGH)) begin
				acc_wr.wr_acc = 3'h2;
			end else if (addr_hit(bus_req.addr, OFS_ACC_UPPER)) begin
				acc_wr.wr_acc = 3'h4;
			end else if (addr_hit(bus_req.addr, OFS_STEP_LOW)) begin
				step_write     = 1'b1;
				step_low_write = 1'b1;
			end else if (addr_hit(bus_req.addr, OFS_STEP_HIGH)) begin
				step_write = 1'b1;
			end else if (addr_hit(bus_req.addr, OFS_STEP_UPPER)) begin
				step_write = 1'b1;
			end
		end
	end

	// step value byte storage
	genvar gi;
	generate
		for (gi = 0; gi < STEP_BYTES; gi++) begin : g_step
			always_ff @(posedge core_clk) begin
				if (reset) begin
					step_value_reg[gi] <= step_reset[gi];
				end else if (step_write && (step_widx == 2'(gi))) begin
					step_value_reg[gi] <= bus_req.wdata;
				end
			end
		end
	endgenerate

	assign step_value = {step_value_reg[STEP_IDX_UPPER][3:0],
		step_value_reg[STEP_IDX_HIGH],
		step_value_reg[STEP_IDX_LOW]};

	// control register
	always_ff @(posedge core_clk) begin
		if (reset) begin
			enable_reg <= RST_CONTROL[CTRL_ENABLE_BIT];
		end else if (bus_req.wr && addr_hit(bus_req.addr, OFS_CONTROL)) begin
			enable_reg <= bus_req.wdata[CTRL_ENABLE_BIT];
		end
	end

	// source clock edges; no synchroniser, input is taken as synchronous
	always_ff @(posedge core_clk) begin
		if (reset) begin
			src_prev_reg <= 1'b0;
		end else begin
			src_prev_reg <= osc_source_clock;
		end
	end

	assign src_rise = osc_source_clock && !src_prev_reg;
	assign src_fall = !osc_source_clock && src_prev_reg;

	// pending until the next falling edge; a new write wins
	always_ff @(posedge core_clk) begin
		if (reset) begin
			shadow_pending_reg <= 1'b0;
		end else if (step_low_write) begin
			shadow_pending_reg <= 1'b1;
		end else if (src_fall) begin
			shadow_pending_reg <= 1'b0;
		end
	end

	// shadow load takes all three bytes at once
	always_ff @(posedge core_clk) begin
		if (reset) begin
			step_shadow_reg <= RST_SHADOW;
		end else if (shadow_pending_reg && src_fall) begin
			step_shadow_reg <= step_value;
		end
	end

	assign step_shadow = step_shadow_reg;

	ncoacc_phase_core u_core (
		.core_clk       (core_clk),
		.reset          (reset),
		.advance        (enable_reg && src_rise),
		.step_in        (step_shadow_reg),
		.acc_wr         (acc_wr),
		.phase_accum    (phase_accum),
		.overflow_pulse (overflow_raw)
	);

	assign osc_overflow = overflow_raw;

	// read mux
	always_comb begin
		rdata_next = READ_UNMAPPED;
		if (addr_hit(bus_req.addr, OFS_ACC_LOW)) begin
			rdata_next = phase_accum[7:0];
		end else if (addr_hit(bus_req.addr, OFS_ACC_HIGH)) begin
			rdata_next = phase_accum[15:8];
		end else if (addr_hit(bus_req.addr, OFS_ACC_UPPER)) begin
			rdata_next = {UPPER_PAD, phase_accum[19:16]};
		end else if (addr_hit(bus_req.addr, OFS_STEP_LOW)) begin
			rdata_next = step_value_reg[STEP_IDX_LOW];
		end else if (addr_hit(bus_req.addr, OFS_STEP_HIGH)) begin
			rdata_next = step_value_reg[STEP_IDX_HIGH];
		end else if (addr_hit(bus_req.addr, OFS_STEP_UPPER)) begin
			rdata_next = {UPPER_PAD, step_value_reg[STEP_IDX_UPPER][3:0]};
		end else if (addr_hit(bus_req.addr, OFS_CONTROL)) begin
			rdata_next = 8'h00;
			rdata_next[CTRL_ENABLE_BIT] = enable_reg;
		end else if (addr_hit(bus_req.addr, OFS_STATUS)) begin
			rdata_next = 8'h00;
			rdata_next[STAT_PENDING_BIT] = shadow_pending_reg;
			rdata_next[STAT_RUNNING_BIT] = enable_reg;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bus_rdata_reg <= READ_UNMAPPED;
		end else if (bus_req.rd) begin
			bus_rdata_reg <= rdata_next;
		end else begin
			bus_rdata_reg <= READ_UNMAPPED;
		end
	end

	assign bus_rdata = bus_rdata_reg;

endmodule : ncoacc_top

/* File: testbench/ncoacc_assertions.sv */
// Purpose: port checker for the oscillator accumulator block
// Assumes: source clock phases last two core cycles or more
// Notes:   enable is internal, so an advance is add or hold
`timescale 1ns/10ps
module ncoacc_assertions
	import ncoacc_pkg::*;
(
	input wire logic               core_clk,
	input wire logic               reset,
	input wire ncoacc_bus_req_type bus_req,
	input wire logic [7:0]         bus_rdata,
	input wire logic               osc_source_clock,
	input wire logic [19:0]        phase_accum,
	input wire logic [19:0]        step_shadow,
	input wire logic               osc_overflow
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence rd_upper;
		bus_req.rd && bus_req.addr == OFS_ACC_UPPER;
	endsequence
	sequence adv_seen;
		$rose(osc_source_clock) && !bus_req.wr;
	endsequence
	a_upper_pad: assert property (rd_upper |=> bus_rdata[7:4] == UPPER_PAD) // pad
		else $error("upper pad not zero");
	a_acc_low: assert property ( // low byte
		bus_req.rd && bus_req.addr == OFS_ACC_LOW |=> bus_rdata == $past(phase_accum[7:0]))
		else $error("low byte read wrong");
	a_acc_high: assert property ( // high byte
		bus_req.rd && bus_req.addr == OFS_ACC_HIGH |=> bus_rdata == $past(phase_accum[15:8]))
		else $error("high byte read wrong");
	a_idle_hold: assert property ( // advance on source
		!$rose(osc_source_clock) && !bus_req.wr |=> $stable(phase_accum))
		else $error("accumulator moved without source edge");
	a_step_add: assert property (adv_seen |=> phase_accum == $past(phase_accum) || // add
		phase_accum == 20'($past(phase_accum) + $past(step_shadow)))
		else $error("advance is not a step add");
	a_carry_drop: assert property (osc_overflow |-> phase_accum < $past(phase_accum)) // carry
		else $error("overflow without wrap");
	a_ovf_single: assert property (osc_overflow |=> !osc_overflow) // pulse
		else $error("overflow longer than one cycle");
	a_shadow_hold: assert property ( // fall only
		!$fell(osc_source_clock) |=> $stable(step_shadow))
		else $error("shadow changed off a falling edge");
	a_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == READ_UNMAPPED) // read window
		else $error("read data outside the read window");
endmodule : ncoacc_assertions

bind ncoacc_top ncoacc_assertions u_chk (.core_clk(core_clk), .reset(reset),
	.bus_req(bus_req), .bus_rdata(bus_rdata), .osc_source_clock(osc_source_clock),
	.phase_accum(phase_accum), .step_shadow(step_shadow), .osc_overflow(osc_overflow));

/* File: testbench/testbench.sv */
// Purpose: directed bench for the accumulator and step registers
// Assumes: source clock driven two core cycles high, then two or more low
// Notes:   the source clock stands low between bursts, so reads see a still value
`timescale 1ns/10ps
module testbench
	import ncoacc_pkg::*;
;
	logic               core_clk;
	logic               reset;
	ncoacc_bus_req_type bus_req;
	logic [7:0]         bus_rdata;
	logic               osc_source_clock;
	logic [19:0]        phase_accum;
	logic [19:0]        step_shadow;
	logic               osc_overflow;
	int                 mismatches;
	int                 check_count;
	int                 ovf_seen;
	int                 ovf_base;
	int                 ovf_exp;
	logic [20:0]        model;
	logic [7:0]         rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00};

	ncoacc_top dut (.core_clk(core_clk), .reset(reset), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .osc_source_clock(osc_source_clock),
		.phase_accum(phase_accum), .step_shadow(step_shadow), .osc_overflow(osc_overflow));

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (osc_overflow === 1'b1) ovf_seen++;
	end

	task automatic check_val(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_val

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask : reg_wr

	task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1 check_val({12'h000, bus_rdata}, {12'h000, e});
	endtask : reg_rd

	// two core cycles high and at least two low, so the sampled edges are never missed
	task automatic osc_cycle();
		@(posedge core_clk);
		osc_source_clock <= 1'b1;
		repeat (2) @(posedge core_clk);
		osc_source_clock <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : osc_cycle

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_of_test

	initial begin
		#200000;
		mismatches++;
		end_of_test();
	end

	initial begin
		reset = 1'b1;
		bus_req = '0;
		osc_source_clock = 1'b0;
		mismatches = 0;
		check_count = 0;
		ovf_exp = 0;
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		foreach (rst_tab[i]) reg_rd(4'(i), rst_tab[i]); // reset table
		check_val(step_shadow, 20'h00001); // shadow reset
		reg_wr(OFS_ACC_LOW, 8'h5a); // idle write
		reg_wr(OFS_ACC_HIGH, 8'ha5); // idle write
		reg_wr(OFS_ACC_UPPER, 8'hff); // idle write
		reg_rd(OFS_ACC_UPPER, 8'h0f); // pad ignored
		check_val(phase_accum, 20'hfa55a); // byte split
		reg_wr(OFS_STEP_UPPER, 8'hfa); // upper first
		reg_wr(OFS_STEP_HIGH, 8'hbc); // high next
		reg_rd(OFS_STEP_UPPER, 8'h0a); // upper nibble
		check_val(step_shadow, 20'h00001); // no load yet
		reg_wr(OFS_STEP_LOW, 8'hde); // low last
		check_val(step_shadow, 20'h00001); // waits for fall
		reg_rd(OFS_STATUS, 8'h01); // load pending
		osc_cycle();
		check_val(step_shadow, 20'habcde); // joined step
		check_val(phase_accum, 20'hfa55a); // disabled holds
		for (int k = 0; k < 3; k++) reg_wr(4'(k), 8'h00); // clear while idle
		reg_wr(OFS_CONTROL, 8'h01);
		reg_rd(OFS_STATUS, 8'h02); // pending cleared
		model = '0;
		ovf_base = ovf_seen;
		for (int k = 0; k < 6; k++) begin
			osc_cycle();
			model = {1'b0, model[19:0]} + 21'h0abcde;
			if (model[20]) ovf_exp++;
		end
		check_val(phase_accum, model[19:0]); // step adds
		check_val(20'(ovf_seen - ovf_base), 20'(ovf_exp)); // carry events
		reg_rd(OFS_ACC_LOW, model[7:0]); // low byte
		reg_rd(OFS_ACC_HIGH, model[15:8]); // high byte
		reg_rd(OFS_ACC_UPPER, {4'h0, model[19:16]}); // upper read
		end_of_test();
	end
endmodule : testbench
